/* src/tx_cell_map.vh */
// Constants and register map of the transmit cell processor configuration block
// Operation
// R1 - Flush control set empties the FIFO and drops writes until cleared.
// R2 - After a flush, idle cells go out until a new cell is written.
// R3 - Payload is scrambled unless the scramble disable bit is one.
// R4 - Coset 0x55 is added to the HEC octet when coset addition is enabled.
// R5 - Coset addition applies to idle cells and FIFO-supplied HEC octets too.
// R6 - HEC is generated and inserted only while the active-low insert bit is zero.
// R7 - Cell available drops after word 24 in full mode, word 19 otherwise.
// R8 - Parity select one checks even parity over the data, zero checks odd.
// R9 - Software writes zero to the reserved bits of the first configuration register.
// R10 - Control byte of word three is XORed into the HEC while disable_n is zero.
// R11 - Error injection inverts the HEC after the control byte XOR, on all cells.
// R12 - Depth field 00,01,10,11 gives threshold of 4,3,2,1 cells.
// R13 - The FIFO always holds four complete cells whatever the threshold.
// R14 - Invert bit flips cell available and direct cell available outputs.
// R15 - Active-low H4 insert one sends 00, zero sends the cell offset.
// R16 - Count update sets transfer flag; status read clears it and overrun.
// R17 - Transfer flag raises the interrupt when its enable is one.
`ifndef TX_CELL_MAP_VH
`define TX_CELL_MAP_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ADDR_CFG_ONE 8'h80
`define ADDR_CFG_TWO 8'h81
`define ADDR_COUNT_STAT 8'h82
`define ADDR_IRQ_STAT 8'h8a
`define ADDR_IRQ_CLEAR 8'h8b
`define ADDR_IRQ_ENABLE 8'h8c
// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define RST_CFG_ONE 8'h04
`define RST_CFG_TWO 5'h00
`define RST_COUNT_OPT 8'h08
`define MASK_COUNT_OPT 8'h8f
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define B1_FLUSH 0
`define B1_SCR_DIS 1
`define B1_COSET 2
`define B1_HEC_N 3
`define B1_FULL_LVL 6
`define B1_PAR_EVEN 7
`define B2_XOR_N 0
`define B2_INJECT 1
`define B2_DEPTH_LO 2
`define B2_DEPTH_HI 3
`define B2_INVERT 4
`define B3_H4_N 2
`define B3_OVR 5
`define B3_XFER 6
`define B3_XFER_EN 7
`define IRQ_SOC 0
`define IRQ_OVF 1
`define IRQ_PAR 2
// ------------------------------------------------------------
// Cell structure
// ------------------------------------------------------------
`define CELL_WORDS 7'd27
`define LAST_WORD 5'd26
`define FIFO_CELLS 3'd4
`define MEM_DEPTH 108
`define WORD_FULL 5'd24
`define WORD_NEAR 5'd19
`define HDR_BYTES 6'd4
`define HEC_BYTE 6'd4
`define PAY_FIRST 6'd5
`define LAST_BYTE 6'd52
`define LINE_CELL 8'd53
`define CTRL_WORD 7'd2
`define PAY_WORD 7'd3
`define COSET 8'h55
`define CRC_POLY 8'h07
`define IDLE_HDR 32'h00000001
`define IDLE_PAY 8'h6a
`define H4_NULL 8'h00
`define SCR_LEN 43
`endif

/* src/tx_cell_processor.v */
// Transmit cell processor: cell FIFO, HEC and scrambler path, configuration registers
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "tx_cell_map.vh"
module tx_cell_processor (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata_r,
  input wire cell_wr,
  input wire cell_soc,
  input wire [15:0] cell_data,
  input wire cell_parity,
  input wire count_update,
  input wire line_en,
  output reg [7:0] line_data_r,
  output reg line_soc_r,
  output reg line_valid_r,
  output reg [7:0] h4_byte_r,
  output reg cell_avail_r,
  output reg direct_cell_avail_r,
  output reg irq_r
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [7:0] cfg_one_r;
  reg [4:0] cfg_two_r;
  reg [7:0] count_opt_r;
  reg xfer_r;
  reg ovr_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_en_r;
  reg [15:0] mem [0:`MEM_DEPTH-1];
  reg [1:0] wr_ptr_r;
  reg [1:0] rd_ptr_r;
  reg [2:0] cells_r;
  reg [4:0] wr_word_r;
  reg [5:0] byte_r;
  reg from_fifo_r;
  reg [`SCR_LEN-1:0] scr_r;

  wire flush = cfg_one_r[`B1_FLUSH];
  wire wr_cfg_one = wr_stb && (addr == `ADDR_CFG_ONE);
  wire wr_cfg_two = wr_stb && (addr == `ADDR_CFG_TWO);
  wire wr_count = wr_stb && (addr == `ADDR_COUNT_STAT);
  wire wr_iclr = wr_stb && (addr == `ADDR_IRQ_CLEAR);
  wire wr_ien = wr_stb && (addr == `ADDR_IRQ_ENABLE);
  wire rd_count = rd_stb && (addr == `ADDR_COUNT_STAT);

  // ------------------------------------------------------------
  // Bus side write path
  // ------------------------------------------------------------
  wire full = (cells_r == `FIFO_CELLS);
  wire par_bad = cfg_one_r[`B1_PAR_EVEN] ? (^{cell_data, cell_parity}) :
    ~(^{cell_data, cell_parity}); // [R8]
  wire soc_bad = cell_wr && cell_soc && (wr_word_r != 5'd0);
  // A misplaced start of cell restarts the structure; that word lands as word zero
  wire [4:0] word_at = cell_soc ? 5'd0 : wr_word_r;
  // Writes are dropped both while flushing and while all four cells are held
  wire wr_ok = cell_wr && !flush && !full; // [R1] [R13]
  wire wr_last = wr_ok && (word_at == `LAST_WORD);
  wire ovf_evt = cell_wr && !flush && full;
  wire [6:0] wr_idx = ({5'h00, wr_ptr_r} * `CELL_WORDS) + {2'b00, word_at};

  // ------------------------------------------------------------
  // Line side read path
  // ------------------------------------------------------------
  wire start_fifo = (cells_r != 3'd0) && !flush; // [R2]
  wire cur_fifo = (byte_r == 6'd0) ? start_fifo : (from_fifo_r && !flush);
  wire [6:0] rd_base = {5'h00, rd_ptr_r} * `CELL_WORDS;
  wire [5:0] pay_off = byte_r - `PAY_FIRST;
  wire [6:0] pay_word = `PAY_WORD + {2'b00, pay_off[5:1]};
  // The HEC slot has no payload word behind it; pointing it at word zero keeps
  // the index inside the array
  wire [6:0] rd_word = (byte_r <= `HEC_BYTE) ? {6'h00, byte_r[1]} : pay_word;
  wire [15:0] rd_val = mem[rd_base + rd_word];
  wire rd_hi = (byte_r < `HDR_BYTES) ? ~byte_r[0] : ~pay_off[0];
  wire [7:0] fifo_byte = rd_hi ? rd_val[15:8] : rd_val[7:0];
  wire [15:0] hdr_w0 = mem[rd_base];
  wire [15:0] hdr_w1 = mem[rd_base + 7'd1];
  wire [15:0] ctl_w = mem[rd_base + `CTRL_WORD];
  wire [31:0] idle_hdr = `IDLE_HDR;
  wire [31:0] hdr = cur_fifo ? {hdr_w0, hdr_w1} : idle_hdr;
  wire [1:0] hsel = 2'd3 - byte_r[1:0];
  wire [7:0] hdr_byte = hdr[{hsel, 3'b000} +: 8];
  wire is_pay = (byte_r >= `PAY_FIRST);
  wire rd_done = line_en && cur_fifo && (byte_r == `LAST_BYTE);

  function [7:0] crc8;
    input [31:0] d;
    integer i;
    reg [7:0] c;
    begin
      c = 8'h00;
      for (i = 31; i >= 0; i = i - 1)
      begin
        if (c[7] ^ d[i])
          c = {c[6:0], 1'b0} ^ `CRC_POLY;
        else
          c = {c[6:0], 1'b0};
      end
      crc8 = c;
    end
  endfunction

  // ------------------------------------------------------------
  // HEC octet
  // ------------------------------------------------------------
  wire [7:0] hec_gen = crc8(hdr);
  wire use_ctl = cur_fifo && !cfg_two_r[`B2_XOR_N];
  wire [7:0] hec_x = use_ctl ? (hec_gen ^ ctl_w[7:0]) : hec_gen; // [R10]
  // With generation off, a FIFO cell keeps its own octet; idle cells carry zero
  wire [7:0] hec_src = cur_fifo ? ctl_w[15:8] : 8'h00;
  wire [7:0] hec_a = cfg_one_r[`B1_HEC_N] ? hec_src : hec_x; // [R6]
  wire [7:0] hec_b = cfg_one_r[`B1_COSET] ? (hec_a ^ `COSET) : hec_a; // [R4] [R5]
  wire [7:0] hec_fin = cfg_two_r[`B2_INJECT] ? ~hec_b : hec_b; // [R11]

  // ------------------------------------------------------------
  // Payload scrambler, self-synchronous over 43 bits
  // ------------------------------------------------------------
  wire [7:0] pay_raw = cur_fifo ? fifo_byte : `IDLE_PAY;
  wire [`SCR_LEN-1:0] scr_st [0:8];
  wire [7:0] pay_scr;
  assign scr_st[0] = scr_r;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : scr_bit
      assign pay_scr[7-g] = pay_raw[7-g] ^ scr_st[g][`SCR_LEN-1];
      assign scr_st[g+1] = {scr_st[g][`SCR_LEN-2:0], pay_scr[7-g]};
    end
  endgenerate
  // State keeps advancing while bypassed; the far end resynchronises within
  // one register length after scrambling is switched back on
  wire [7:0] pay_out = cfg_one_r[`B1_SCR_DIS] ? pay_raw : pay_scr; // [R3]

  reg [7:0] byte_out;
  always @*
  begin
    if (byte_r < `HDR_BYTES)
      byte_out = hdr_byte;
    else if (byte_r == `HEC_BYTE)
      byte_out = hec_fin;
    else
      byte_out = pay_out;
  end

  // ------------------------------------------------------------
  // Cell available level
  // ------------------------------------------------------------
  reg [2:0] depth;
  always @*
  begin
    case ({cfg_two_r[`B2_DEPTH_HI], cfg_two_r[`B2_DEPTH_LO]}) // [R12]
      2'b00: depth = 3'd4;
      2'b01: depth = 3'd3;
      2'b10: depth = 3'd2;
      2'b11: depth = 3'd1;
      default: depth = 3'd4;
    endcase
  end

  // A finished write and a finished read in one cycle cancel out
  reg [2:0] cells_nxt;
  reg [4:0] word_nxt;
  always @*
  begin
    cells_nxt = cells_r;
    if (wr_last && !rd_done)
      cells_nxt = cells_r + 3'd1;
    else if (rd_done && !wr_last)
      cells_nxt = cells_r - 3'd1;
    word_nxt = wr_word_r;
    if (cell_wr && cell_soc)
      word_nxt = 5'd0;
    if (wr_ok)
      word_nxt = wr_last ? 5'd0 : word_at + 5'd1;
    if (flush)
    begin
      cells_nxt = 3'd0;
      word_nxt = 5'd0;
    end
  end

  // The transfer in progress counts once its word count reaches the level
  wire [4:0] lvl_word = cfg_one_r[`B1_FULL_LVL] ? `WORD_FULL : `WORD_NEAR;
  wire pend = (word_nxt >= lvl_word);
  wire [2:0] level = cells_nxt + {2'b00, pend};
  wire avail_nxt = (level < depth) ^ cfg_two_r[`B2_INVERT]; // [R7] [R14]

  // ------------------------------------------------------------
  // Status next values; a set in the clearing cycle wins
  // ------------------------------------------------------------
  wire xfer_nxt = count_update || (xfer_r && !rd_count); // [R16]
  wire ovr_nxt = (count_update && xfer_r) || (ovr_r && !rd_count); // [R16]
  wire [2:0] ievt = {cell_wr && par_bad, ovf_evt, soc_bad};
  wire [2:0] iclr = wr_iclr ? wdata[2:0] : 3'b000;
  wire [2:0] istat_nxt = ievt | (irq_stat_r & ~iclr);
  wire [2:0] ien_nxt = wr_ien ? wdata[2:0] : irq_en_r;
  wire [7:0] copt_nxt = wr_count ? (wdata & `MASK_COUNT_OPT) : count_opt_r;
  // Next-state values let the interrupt rise together with its status bit
  wire irq_nxt = (|(istat_nxt & ien_nxt)) ||
    (xfer_nxt && copt_nxt[`B3_XFER_EN]); // [R17]

  reg [7:0] rd_mux;
  always @*
  begin
    case (addr)
      `ADDR_CFG_ONE: rd_mux = cfg_one_r;
      `ADDR_CFG_TWO: rd_mux = {3'b000, cfg_two_r};
      `ADDR_COUNT_STAT: rd_mux = {count_opt_r[7], xfer_r, ovr_r, count_opt_r[4:0]};
      `ADDR_IRQ_STAT: rd_mux = {5'h00, irq_stat_r};
      `ADDR_IRQ_ENABLE: rd_mux = {5'h00, irq_en_r};
      default: rd_mux = 8'h00;
    endcase
  end

  wire [7:0] line_cell_m1 = `LINE_CELL - {2'b00, byte_r};
  wire [5:0] byte_nxt = (byte_r == `LAST_BYTE) ? 6'd0 : byte_r + 6'd1;

  // ------------------------------------------------------------
  // Path overhead pointer byte
  // ------------------------------------------------------------
  // Tracks the line position every cycle, so a change of the insert control
  // shows at once rather than at the next line byte
  reg [7:0] h4_nxt;
  always @*
  begin
    if (cfg_count_h4_n(count_opt_r))
      h4_nxt = `H4_NULL; // [R15]
    else if (byte_r == 6'd0)
      h4_nxt = `H4_NULL;
    else
      h4_nxt = line_cell_m1; // [R15]
  end

  always @(posedge clk)
  begin
    if (!nrst)
      h4_byte_r <= `H4_NULL;
    else if (ce)
      h4_byte_r <= h4_nxt;
  end

  // ------------------------------------------------------------
  // FIFO storage, no reset needed on data
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (ce && wr_ok)
      mem[wr_idx] <= cell_data;
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      cfg_one_r <= `RST_CFG_ONE;
      cfg_two_r <= `RST_CFG_TWO;
      count_opt_r <= `RST_COUNT_OPT;
      xfer_r <= 1'b0;
      ovr_r <= 1'b0;
      irq_stat_r <= 3'b000;
      irq_en_r <= 3'b000;
      wr_ptr_r <= 2'd0;
      rd_ptr_r <= 2'd0;
      cells_r <= 3'd0;
      wr_word_r <= 5'd0;
      byte_r <= 6'd0;
      from_fifo_r <= 1'b0;
      scr_r <= {`SCR_LEN{1'b0}};
      rdata_r <= 8'h00;
      line_data_r <= 8'h00;
      line_soc_r <= 1'b0;
      line_valid_r <= 1'b0;
      cell_avail_r <= 1'b1;
      direct_cell_avail_r <= 1'b1;
      irq_r <= 1'b0;
    end
    else if (ce)
    begin
      // Reserved bits are stored as written; software keeps them at zero
      if (wr_cfg_one)
        cfg_one_r <= wdata; // [R9]
      if (wr_cfg_two)
        cfg_two_r <= wdata[4:0];
      count_opt_r <= copt_nxt;
      xfer_r <= xfer_nxt;
      ovr_r <= ovr_nxt;
      irq_stat_r <= istat_nxt;
      irq_en_r <= ien_nxt;
      // Read data stand for one cycle only and are zero otherwise
      rdata_r <= rd_stb ? rd_mux : 8'h00;
      irq_r <= irq_nxt;
      cells_r <= cells_nxt;
      wr_word_r <= word_nxt;
      cell_avail_r <= avail_nxt;
      direct_cell_avail_r <= avail_nxt; // [R14]
      // A flush in mid-cell sends the rest of that cell as idle bytes, so the
      // line never sees a short cell
      if (flush)
      begin
        wr_ptr_r <= 2'd0; // [R1]
        rd_ptr_r <= 2'd0;
        from_fifo_r <= 1'b0;
      end
      else
      begin
        if (wr_last)
          wr_ptr_r <= wr_ptr_r + 2'd1;
        if (rd_done)
          rd_ptr_r <= rd_ptr_r + 2'd1;
      end
      line_valid_r <= line_en;
      if (line_en)
      begin
        line_data_r <= byte_out;
        line_soc_r <= (byte_r == 6'd0);
        byte_r <= byte_nxt;
        if (byte_r == 6'd0)
          from_fifo_r <= start_fifo; // [R2]
        if (is_pay)
          scr_r <= scr_st[8];
      end
    end
  end

  function cfg_count_h4_n;
    input [7:0] v;
    begin
      cfg_count_h4_n = v[`B3_H4_N];
    end
  endfunction

endmodule // tx_cell_processor

/* verification/atm_cell_source.sv */
// Bus-side model that writes 27-word cells into the transmit FIFO
`timescale 1ns/1ps
module atm_cell_source (
  input wire clk,
  input wire go,
  input wire restart,
  input wire [4:0] nwords,
  input wire [7:0] base,
  input wire even_par,
  input wire bad_par,
  output reg cell_wr,
  output reg cell_soc,
  output reg [15:0] cell_data,
  output reg cell_parity,
  output wire busy
);
  reg [4:0] left_r = 5'h00;
  reg [4:0] word_r = 5'h00;
  // Word 2 carries the HEC byte and the control byte
  wire [7:0] hi = base + {2'b00, word_r, 1'b0};
  wire [15:0] w = {hi, hi + 8'h01};
  wire act = busy && !go;
  assign busy = (left_r != 5'h00);
  initial
  begin
    cell_wr = 1'b0;
    cell_soc = 1'b0;
    cell_data = 16'h0000;
    cell_parity = 1'b0;
  end
  always @(posedge clk)
  begin
    if (go)
    begin
      left_r <= nwords;
      if (restart) word_r <= 5'h00;
    end
    else if (busy)
    begin
      left_r <= left_r - 5'h01;
      word_r <= (word_r == 5'd26) ? 5'h00 : word_r + 5'h01;
    end
  end
  // Idle bus shows the inverse, so a stale word is never mistaken for data
  always @(posedge clk)
  begin
    cell_wr <= act;
    cell_soc <= act && word_r == 5'h00;
    cell_data <= act ? w : ~cell_data;
    cell_parity <= act ? (^w ^ !even_par ^ bad_par) : ~cell_parity;
  end
endmodule // atm_cell_source

/* verification/tx_cell_monitor.sv */
// Port checker for the transmit cell processor
`timescale 1ns/1ps
module tx_cell_monitor (
  input wire clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata_r,
  input wire count_update,
  input wire line_soc_r,
  input wire [7:0] h4_byte_r,
  input wire cell_avail_r,
  input wire direct_cell_avail_r,
  input wire irq_r
);
  // ----------
  // Register shadows built from bus writes only
  // ----------
  reg [7:0] c1_r;
  reg [7:0] c82_r;
  reg [7:0] en_r;
  reg inv_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      c1_r <= 8'h04;
      c82_r <= 8'h08;
      en_r <= 8'h00;
      inv_r <= 1'b0;
    end
    else if (wr_stb)
    begin
      if (addr == 8'h80) c1_r <= wdata;
      if (addr == 8'h82) c82_r <= wdata;
      if (addr == 8'h8c) en_r <= wdata;
      if (addr == 8'h81) inv_r <= wdata[4];
    end
  end
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_avail_mirror: assert property (direct_cell_avail_r == cell_avail_r)
    else $error("direct cell available differs");
  a_flush_space: assert property ((c1_r[0] && !wr_stb)[*4] |-> cell_avail_r == !inv_r)
    else $error("space not shown while flushing");
  a_h4_zero: assert property ((c82_r[2])[*3] |-> h4_byte_r == 8'h00)
    else $error("h4 byte not zero");
  a_irq_quiet: assert property ((en_r[2:0] == 3'h0 && !c82_r[7])[*2] |-> !irq_r)
    else $error("interrupt with all sources off");
  a_irq_rise: assert property (count_update && c82_r[7] && !wr_stb |=> irq_r)
    else $error("no interrupt after count transfer");
  a_flag_clear: assert property (rd_stb && addr == 8'h82 && !count_update
    && en_r[2:0] == 3'h0 |=> !irq_r)
    else $error("status read left interrupt up");
  a_cfg_readback: assert property (rd_stb && addr == 8'h80 |=> rdata_r == c1_r)
    else $error("first config readback wrong");
  a_opt_readback: assert property (rd_stb && addr == 8'h82
    |=> rdata_r[7] == c82_r[7] && rdata_r[3:0] == c82_r[3:0] && !rdata_r[4])
    else $error("count options readback wrong");
  c_soc: cover property (line_soc_r);
  c_irq: cover property (irq_r);
  c_flush: cover property (c1_r[0] ##1 !c1_r[0]);
endmodule // tx_cell_monitor
bind tx_cell_processor tx_cell_monitor tx_cell_monitor_i (.clk, .nrst, .addr, .wdata,
  .wr_stb, .rd_stb, .rdata_r, .count_update, .line_soc_r, .h4_byte_r, .cell_avail_r,
  .direct_cell_avail_r, .irq_r);

/* verification/tx_cell_processor_tb_top.sv */
// Self-checking bench for the transmit cell processor
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
  err_count = err_count + 1; $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module tx_cell_processor_tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg count_update = 1'b0;
  reg line_en = 1'b0;
  reg go = 1'b0;
  reg rs = 1'b0;
  reg bad = 1'b0;
  reg pe = 1'b0;
  reg [4:0] nw = 5'h00;
  reg [7:0] base = 8'h00;
  reg [7:0] b;
  reg [7:0] h4c;
  reg [7:0] cap [0:52];
  wire cell_wr, cell_soc, cell_parity, busy, line_soc_r, line_valid_r;
  wire cell_avail_r, direct_cell_avail_r, irq_r;
  wire [15:0] cell_data;
  wire [7:0] rdata_r, line_data_r, h4_byte_r;
  wire [31:0] hdr = {cap[0], cap[1], cap[2], cap[3]};
  integer err_count = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer i, j;
  always #2 clk = ~clk;
  tx_cell_processor tx_cell_processor_i (.clk, .nrst, .ce(1'b1), .addr, .wdata, .wr_stb,
    .rd_stb, .rdata_r, .cell_wr, .cell_soc, .cell_data, .cell_parity, .count_update,
    .line_en, .line_data_r, .line_soc_r, .line_valid_r, .h4_byte_r, .cell_avail_r,
    .direct_cell_avail_r, .irq_r);
  atm_cell_source atm_cell_source_i (.clk, .go, .restart(rs), .nwords(nw), .base,
    .even_par(pe), .bad_par(bad), .cell_wr, .cell_soc, .cell_data, .cell_parity, .busy);
  // ----------
  // Helpers
  // ----------
  function [7:0] crc8(input [31:0] d);
    integer k;
    reg [7:0] c;
  begin
    c = 8'h00;
    for (k = 31; k >= 0; k = k - 1)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
    crc8 = c;
  end
  endfunction
  function [31:0] hw(input [7:0] v);
    hw = {v, v + 8'h01, v + 8'h02, v + 8'h03};
  endfunction
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 `CHK(rdata_r, e)
  end
  endtask
  task send(input [4:0] n, input [7:0] v, input r, input x);
    integer k;
  begin
    @(posedge clk);
    go <= 1'b1;
    nw <= n;
    base <= v;
    rs <= r;
    bad <= x;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 40 && (k < 2 || busy); k = k + 1) @(posedge clk);
    // Last word is taken one edge later and the flag is registered on that same edge
    repeat (3) @(posedge clk);
    #1;
  end
  endtask
  task get_cell;
    integer k;
  begin
    @(posedge clk);
    line_en <= 1'b1;
    for (k = 0; k < 53; k = k + 1)
    begin
      @(posedge clk);
      if (k == 52) line_en <= 1'b0;
      #1 cap[k] = line_data_r;
      if (k == 0) `CHK({line_soc_r, line_valid_r}, 2'b11)
      if (k == 4) h4c = h4_byte_r;
    end
  end
  endtask
  task pulse;
  begin
    @(posedge clk);
    count_update <= 1'b1;
    @(posedge clk);
    count_update <= 1'b0;
    #1;
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // Whole run needs well under 10000 cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      err_count = err_count + 1;
      close_out;
    end
  end
  // ----------
  // Tests
  // ----------
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h80, 8'h04);
    rd(8'h81, 8'h00);
    rd(8'h82, 8'h08);
    rd(8'h8b, 8'h00);
    rd(8'h90, 8'h00);
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h80, 8'h05);
      wr(8'h80, 8'h04);
      wr(8'h81, {3'b000, i[2:0], 2'b00});
      for (j = 0; j < 3 - i[1:0]; j = j + 1) send(27, 8'h00, 1'b1, 1'b0);
      `CHK(cell_avail_r, !i[2])
      send(18, 8'h00, 1'b1, 1'b0);
      `CHK(cell_avail_r, !i[2])
      send(1, 8'h00, 1'b0, 1'b0);
      `CHK(cell_avail_r, i[2])
      `CHK(direct_cell_avail_r, i[2])
    end
    wr(8'h80, 8'h45);
    wr(8'h80, 8'h44);
    wr(8'h81, 8'h0c);
    send(19, 8'h00, 1'b1, 1'b0);
    `CHK(cell_avail_r, 1'b1)
    send(5, 8'h00, 1'b0, 1'b0);
    `CHK(cell_avail_r, 1'b0)
    $display("test fill level done");
    wr(8'h80, 8'h07);
    wr(8'h80, 8'h06);
    for (i = 0; i < 4; i = i + 1) send(27, {i[3:0], 4'h0}, 1'b1, 1'b0);
    rd(8'h8a, 8'h00);
    send(27, 8'h80, 1'b1, 1'b0);
    rd(8'h8a, 8'h02);
    wr(8'h8c, 8'h02);
    `CHK(irq_r, 1'b1)
    wr(8'h8c, 8'h00);
    `CHK(irq_r, 1'b0)
    wr(8'h8c, 8'h02);
    wr(8'h8b, 8'h02);
    rd(8'h8a, 8'h00);
    `CHK(irq_r, 1'b0)
    for (i = 0; i < 4; i = i + 1)
    begin
      b = {i[3:0], 4'h0};
      get_cell;
      `CHK(hdr, hw(b))
      `CHK(cap[4], crc8(hw(b)) ^ (b + 8'h05) ^ 8'h55)
      `CHK(cap[52], b + 8'h35)
      `CHK(h4c, 8'h31)
    end
    get_cell;
    `CHK(hdr, 32'h00000001)
    $display("test fifo done");
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h80, {4'h0, i[0], i[1], 2'b10});
      wr(8'h81, {6'h03, i[2], 1'b0});
      get_cell;
      b = (i[0] ? 8'h00 : crc8(32'h1)) ^ (i[1] ? 8'h55 : 8'h00) ^ {8{i[2]}};
      `CHK(cap[4], b)
    end
    wr(8'h81, 8'h0f);
    wr(8'h80, 8'h04);
    send(27, 8'h40, 1'b1, 1'b0);
    get_cell;
    `CHK(cap[4], ~(crc8(hw(8'h40)) ^ 8'h55))
    j = 0;
    for (i = 5; i < 53; i = i + 1) if (cap[i] !== 8'h41 + i[7:0]) j = j + 1;
    `CHK(j != 0, 1'b1)
    $display("test hec done");
    send(27, 8'h50, 1'b1, 1'b0);
    wr(8'h80, 8'h07);
    send(27, 8'h60, 1'b1, 1'b0);
    wr(8'h80, 8'h06);
    get_cell;
    `CHK(hdr, 32'h00000001)
    send(27, 8'h70, 1'b1, 1'b0);
    get_cell;
    `CHK(hdr, hw(8'h70))
    $display("test flush done");
    wr(8'h8b, 8'h07);
    for (i = 0; i < 2; i = i + 1)
    begin
      pe <= i[0];
      wr(8'h80, {i[0], 7'h06});
      send(27, 8'h20, 1'b1, 1'b0);
      rd(8'h8a, 8'h00);
      send(27, 8'h20, 1'b1, 1'b1);
      rd(8'h8a, 8'h04);
      wr(8'h8b, 8'h04);
    end
    $display("test parity done");
    wr(8'h8c, 8'h00);
    wr(8'h82, 8'h88);
    pulse;
    `CHK(irq_r, 1'b1)
    rd(8'h82, 8'hc8);
    `CHK(irq_r, 1'b0)
    pulse;
    pulse;
    rd(8'h82, 8'he8);
    wr(8'h82, 8'h0c);
    pulse;
    `CHK(irq_r, 1'b0)
    rd(8'h82, 8'h4c);
    get_cell;
    `CHK({h4c, h4_byte_r}, 16'h0000)
    $display("test count done");
    close_out;
  end
endmodule // tx_cell_processor_tb_top
